// *** fci_pkg.sv ***
// ----------------------------------------------------------------------------
// Shared constants for the fast count inputs
// ----------------------------------------------------------------------------
package fci_pkg;

    // Channel count and accumulator width
    localparam int FCI_CHANNELS = 4;
    localparam int FCI_ACC_W = 32;

    // Clock and timing base
    localparam int FCI_CLK_PERIOD_NS = 5;
    localparam int FCI_RESOLUTION_US = 1;
    localparam int FCI_NS_PER_US = 1000;
    localparam int FCI_TICK_CYCLES = (FCI_RESOLUTION_US * FCI_NS_PER_US) / FCI_CLK_PERIOD_NS;
    localparam int FCI_US_PER_S = 1000000;
    // Least edge spacing the sources must keep, in microseconds
    localparam int FCI_MIN_EDGE_GAP_US = 100;

    // Frequency sample windows in microseconds, longest first
    localparam int FCI_WIN0_US = 1000000;
    localparam int FCI_WIN1_US = 100000;
    localparam int FCI_WIN2_US = 10000;
    localparam int FCI_WIN3_US = 1000;

    // Register map, word addresses on the plain register port
    localparam int FCI_ADDR_W = 4;
    localparam logic [3:0] FCI_ADDR_CTRL = 4'h0;
    localparam logic [1:0] FCI_PAGE_CFG = 2'h1;
    localparam logic [1:0] FCI_PAGE_CPR = 2'h2;
    localparam logic [1:0] FCI_PAGE_ACC = 2'h3;

    // Control register fields
    localparam int FCI_CTRL_RST_LSB = 0;
    localparam int FCI_CTRL_HWEN_LSB = 4;
    localparam int FCI_CTRL_HWEDGE_LSB = 6;

    // Channel configuration fields
    localparam int FCI_CFG_MODE_LSB = 0;
    localparam int FCI_CFG_EDGE_BIT = 2;
    localparam int FCI_CFG_WIN_LSB = 3;

    // Reset values
    localparam logic [31:0] FCI_ACC_RST = 32'h0000_0000;
    localparam logic [31:0] FCI_CPR_RST = 32'h0000_0000;
    localparam logic [3:0] FCI_RSTBITS_RST = 4'h0;

    // Measurement modes
    typedef enum logic [1:0] {
        FCI_MODE_FREQ = 2'h0,
        FCI_MODE_TOTAL = 2'h1,
        FCI_MODE_PULSE = 2'h2,
        FCI_MODE_QUAD = 2'h3
    } fci_mode_t;

endpackage

// *** fci_input_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser with edge detection for one pin
module fci_input_sync
    import fci_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_pin,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } fci_sync_state_t;

    fci_sync_state_t state_reg;
    fci_sync_state_t state_next;

    // Only the second stage and its delayed copy feed the edge logic
    always_comb begin
        state_next = state_reg;
        state_next.meta = i_pin;
        state_next.sync = state_reg.meta;
        state_next.prev = state_reg.sync;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Each transition yields exactly one pulse
    assign o_level = state_reg.sync;
    assign o_rise = state_reg.sync & ~state_reg.prev; // RL14
    assign o_fall = ~state_reg.sync & state_reg.prev; // RL14

endmodule

`default_nettype wire

// *** fci_tick.sv ***
`timescale 1ns/100ps
`default_nettype none

// One-cycle pulse every timing resolution step
module fci_tick
    import fci_pkg::*;
#(
    parameter int TICK_CYCLES = FCI_TICK_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    output logic o_tick
);

    typedef struct packed {
        logic [15:0] count;
        logic tick;
    } fci_tick_state_t;

    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

    fci_tick_state_t state_reg;
    fci_tick_state_t state_next;

    // Free-running divider, tick registered so it is glitch free
    always_comb begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (state_reg.count == TICK_LAST) begin
            state_next.count = 16'h0000;
            state_next.tick = 1'b1; // RL4
        end else begin
            state_next.count = state_reg.count + 16'h0001;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_tick = state_reg.tick;

endmodule

`default_nettype wire

// *** fci_counter_top.sv ***
// What this block does
// (RL1) Four inputs, each frequency, totalize, pulse, quadrature
// (RL2) Multi-input modes claim partner inputs exclusively
// (RL3) Each result readable as analog input word
// (RL4) Edges resolved to one microsecond
// (RL5) Sources keep edges 100 us apart
// (RL6) Edge select acts on raw positive logic
// (RL7) Frequency mode reports cycles per second
// (RL8) Four selectable frequency sample windows
// (RL9) Totalize counts configured rising or falling edge
// (RL10) Nonzero counts-per-rev wraps after value minus one
// (RL11) Zero counts-per-rev wraps full 32 bits
// (RL12) Reset bits clear and hold totalizers
// (RL13) Inputs three, four reset totalizers one, two
// (RL14) Inputs synchronised, each edge counted once
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module fci_counter_top
    import fci_pkg::*;
#(
    parameter int WIN0_US = FCI_WIN0_US,
    parameter int WIN1_US = FCI_WIN1_US,
    parameter int WIN2_US = FCI_WIN2_US,
    parameter int WIN3_US = FCI_WIN3_US,
    parameter int TICK_CYCLES = FCI_TICK_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [3:0] i_fast_count_input,
    input wire logic [FCI_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    output logic [31:0] o_rd_data,
    output logic [3:0][31:0] o_analog_input_word
);

    // ------------------------------------------------------------------------
    // Derived constants
    // ------------------------------------------------------------------------
    localparam logic [31:0] WIN0_LAST = 32'(WIN0_US - 1);
    localparam logic [31:0] WIN1_LAST = 32'(WIN1_US - 1);
    localparam logic [31:0] WIN2_LAST = 32'(WIN2_US - 1);
    localparam logic [31:0] WIN3_LAST = 32'(WIN3_US - 1);
    localparam logic [31:0] SCALE0 = 32'(FCI_US_PER_S / WIN0_US);
    localparam logic [31:0] SCALE1 = 32'(FCI_US_PER_S / WIN1_US);
    localparam logic [31:0] SCALE2 = 32'(FCI_US_PER_S / WIN2_US);
    localparam logic [31:0] SCALE3 = 32'(FCI_US_PER_S / WIN3_US);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [3:0][1:0] cfg_mode;
        logic [3:0] cfg_edge;
        logic [3:0][1:0] cfg_win;
        logic [3:0][31:0] cfg_cpr;
        logic [3:0] counter_reset_bits;
        logic [1:0] hw_rst_en;
        logic [1:0] hw_rst_edge;
        logic [3:0][31:0] acc;
        logic [3:0][31:0] win_cnt;
        logic [3:0][31:0] edge_cnt;
        logic [3:0][31:0] pw_cnt;
        logic [3:0] pw_run;
        logic [31:0] rd_data;
    } fci_state_t;

    fci_state_t state_reg;
    fci_state_t state_next;

    logic tick;
    logic [3:0] lvl;
    logic [3:0] rise;
    logic [3:0] fall;

    // ------------------------------------------------------------------------
    // Input conditioning and time base
    // ------------------------------------------------------------------------
    // Every pin is synchronised before any edge logic looks at it
    for (genvar g = 0; g < FCI_CHANNELS; g++) begin : g_in
        fci_input_sync u_sync (
            .i_clock(i_clock),
            .i_rst_n(i_rst_n),
            .i_pin(i_fast_count_input[g]),
            .o_level(lvl[g]),
            .o_rise(rise[g]),
            .o_fall(fall[g])
        );
    end

    fci_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .o_tick(tick)
    );

    // Window selection helpers
    function automatic logic [31:0] win_last(input logic [1:0] sel);
        logic [31:0] v;
        case (sel)
            2'h0: v = WIN0_LAST;
            2'h1: v = WIN1_LAST;
            2'h2: v = WIN2_LAST;
            default: v = WIN3_LAST;
        endcase
        return v;
    endfunction

    function automatic logic [31:0] win_scale(input logic [1:0] sel);
        logic [31:0] v;
        case (sel)
            2'h0: v = SCALE0;
            2'h1: v = SCALE1;
            2'h2: v = SCALE2;
            default: v = SCALE3;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------------------
    // Measurement and register logic
    // ------------------------------------------------------------------------
    // Claims are checked first so a partner input never runs on its own
    always_comb begin
        logic [3:0] claimed;
        logic [1:0] hw_evt;
        logic act_edge;
        logic end_edge;
        logic up;
        logic dn;
        logic la;
        logic lb;
        logic [31:0] ecnt;
        logic [1:0] idx;
        logic [31:0] cpr_m1;
        state_next = state_reg;
        state_next.rd_data = 32'h0000_0000;
        claimed = 4'h0;
        hw_evt = 2'h0;
        act_edge = 1'b0;
        end_edge = 1'b0;
        up = 1'b0;
        dn = 1'b0;
        la = 1'b0;
        lb = 1'b0;
        ecnt = 32'h0000_0000;
        idx = i_addr[1:0];
        cpr_m1 = 32'h0000_0000;

        // Quadrature takes the next input, hardware reset takes its source
        claimed[1] = (state_reg.cfg_mode[0] == FCI_MODE_QUAD); // RL2
        claimed[3] = (state_reg.cfg_mode[2] == FCI_MODE_QUAD); // RL2
        claimed[2] = state_reg.hw_rst_en[0]; // RL2
        claimed[3] = claimed[3] | state_reg.hw_rst_en[1]; // RL2

        // Inputs three and four act as edge resets for totalizers one and two
        for (int k = 0; k < 2; k++) begin
            hw_evt[k] = state_reg.hw_rst_en[k] &
                (state_reg.hw_rst_edge[k] ? fall[k+2] : rise[k+2]); // RL13
        end

        for (int c = 0; c < FCI_CHANNELS; c++) begin
            // Edge choice applies to the pin level as seen, positive logic
            act_edge = state_reg.cfg_edge[c] ? fall[c] : rise[c]; // RL6
            end_edge = state_reg.cfg_edge[c] ? rise[c] : fall[c];
            cpr_m1 = state_reg.cfg_cpr[c] - 32'h0000_0001;
            if (claimed[c] || (state_reg.cfg_mode[c] == FCI_MODE_QUAD && c[0])) begin
                // Claimed input shows zero and keeps no count of its own
                state_next.acc[c] = FCI_ACC_RST; // RL2
                state_next.win_cnt[c] = 32'h0000_0000;
                state_next.edge_cnt[c] = 32'h0000_0000;
                state_next.pw_run[c] = 1'b0;
            end else begin
                case (state_reg.cfg_mode[c])
                    FCI_MODE_FREQ: begin
                        // Rising edges counted over the selected window
                        ecnt = state_reg.edge_cnt[c] + {31'h0, rise[c]};
                        if (tick && state_reg.win_cnt[c] == win_last(state_reg.cfg_win[c])) begin // RL8
                            state_next.acc[c] = 32'(ecnt * win_scale(state_reg.cfg_win[c])); // RL7
                            state_next.win_cnt[c] = 32'h0000_0000;
                            state_next.edge_cnt[c] = 32'h0000_0000;
                        end else begin
                            state_next.edge_cnt[c] = ecnt;
                            if (tick) begin
                                state_next.win_cnt[c] = state_reg.win_cnt[c] + 32'h0000_0001; // RL4
                            end
                        end
                    end
                    FCI_MODE_TOTAL: begin
                        // Level reset wins over any edge while it is held
                        if (state_reg.counter_reset_bits[c] || (c < 2 && hw_evt[c[0]])) begin
                            state_next.acc[c] = FCI_ACC_RST; // RL12
                        end else if (act_edge) begin // RL9
                            if (state_reg.cfg_cpr[c] != 32'h0000_0000 && state_reg.acc[c] == cpr_m1) begin
                                state_next.acc[c] = FCI_ACC_RST; // RL10
                            end else begin
                                state_next.acc[c] = state_reg.acc[c] + 32'h0000_0001; // RL11
                            end
                        end
                    end
                    FCI_MODE_PULSE: begin
                        // Width of the selected level in microsecond counts
                        if (act_edge) begin
                            state_next.pw_cnt[c] = 32'h0000_0000;
                            state_next.pw_run[c] = 1'b1;
                        end else if (end_edge) begin
                            if (state_reg.pw_run[c]) begin
                                state_next.acc[c] = state_reg.pw_cnt[c];
                            end
                            state_next.pw_run[c] = 1'b0;
                        end else if (state_reg.pw_run[c] && tick) begin
                            state_next.pw_cnt[c] = state_reg.pw_cnt[c] + 32'h0000_0001; // RL4
                        end
                    end
                    FCI_MODE_QUAD: begin
                        // Four counts per cycle; edge bit reverses direction
                        la = lvl[c];
                        lb = lvl[c|1];
                        up = (rise[c] & ~lb) | (la & rise[c|1]) | (fall[c] & lb) | (~la & fall[c|1]);
                        dn = (rise[c] & lb) | (~la & rise[c|1]) | (fall[c] & ~lb) | (la & fall[c|1]);
                        if (state_reg.cfg_edge[c]) begin
                            {up, dn} = {dn, up};
                        end
                        if (state_reg.counter_reset_bits[c]) begin
                            state_next.acc[c] = FCI_ACC_RST;
                        end else if (up) begin
                            if (state_reg.cfg_cpr[c] != 32'h0000_0000 && state_reg.acc[c] == cpr_m1) begin
                                state_next.acc[c] = FCI_ACC_RST;
                            end else begin
                                state_next.acc[c] = state_reg.acc[c] + 32'h0000_0001;
                            end
                        end else if (dn) begin
                            if (state_reg.acc[c] == 32'h0000_0000 && state_reg.cfg_cpr[c] != 32'h0000_0000) begin
                                state_next.acc[c] = cpr_m1;
                            end else begin
                                state_next.acc[c] = state_reg.acc[c] - 32'h0000_0001;
                            end
                        end
                    end
                    default: begin
                        state_next.acc[c] = state_reg.acc[c];
                    end
                endcase
            end
        end

        // Register writes; a write to the configuration page restarts that channel
        if (i_wr_stb) begin
            if (i_addr == FCI_ADDR_CTRL) begin
                state_next.counter_reset_bits = i_wr_data[FCI_CTRL_RST_LSB +: 4]; // RL12
                state_next.hw_rst_en = i_wr_data[FCI_CTRL_HWEN_LSB +: 2]; // RL13
                state_next.hw_rst_edge = i_wr_data[FCI_CTRL_HWEDGE_LSB +: 2]; // RL13
            end else if (i_addr[3:2] == FCI_PAGE_CFG) begin
                state_next.cfg_mode[idx] = i_wr_data[FCI_CFG_MODE_LSB +: 2]; // RL1
                state_next.cfg_edge[idx] = i_wr_data[FCI_CFG_EDGE_BIT]; // RL9
                state_next.cfg_win[idx] = i_wr_data[FCI_CFG_WIN_LSB +: 2]; // RL8
                state_next.acc[idx] = FCI_ACC_RST;
                state_next.win_cnt[idx] = 32'h0000_0000;
                state_next.edge_cnt[idx] = 32'h0000_0000;
                state_next.pw_run[idx] = 1'b0;
            end else if (i_addr[3:2] == FCI_PAGE_CPR) begin
                state_next.cfg_cpr[idx] = i_wr_data; // RL10
            end
        end

        // Register reads, answered in the following cycle only
        if (i_rd_stb) begin
            if (i_addr == FCI_ADDR_CTRL) begin
                state_next.rd_data = {24'h0, state_reg.hw_rst_edge, state_reg.hw_rst_en,
                    state_reg.counter_reset_bits};
            end else if (i_addr[3:2] == FCI_PAGE_CFG) begin
                state_next.rd_data = {27'h0, state_reg.cfg_win[idx], state_reg.cfg_edge[idx],
                    state_reg.cfg_mode[idx]};
            end else if (i_addr[3:2] == FCI_PAGE_CPR) begin
                state_next.rd_data = state_reg.cfg_cpr[idx];
            end else if (i_addr[3:2] == FCI_PAGE_ACC) begin
                state_next.rd_data = state_reg.acc[idx]; // RL3
            end
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= '0;
            state_reg.counter_reset_bits <= FCI_RSTBITS_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Accumulators also leave as words for the program side
    assign o_analog_input_word = state_reg.acc; // RL3
    assign o_rd_data = state_reg.rd_data;

endmodule

`default_nettype wire

// *** fci_counter_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// Port checker for the fast count inputs
// ----------------------------------------------------------------------------
module fci_counter_asserts
    import fci_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [3:0] i_fast_count_input,
    input wire logic [FCI_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    input wire logic [31:0] o_rd_data,
    input wire logic [3:0][31:0] o_analog_input_word
);
    logic [7:0] ctrl_reg;
    logic [4:0] cfg0_reg;
    logic [4:0] cfg1_reg;
    logic [31:0] cpr1_reg;
    logic [31:0] acc_rd_reg;
    logic tot0;
    logic tot1;

    // Shadows of written settings; the checker sees only ports
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg <= 8'h00;
            cfg0_reg <= 5'h00;
            cfg1_reg <= 5'h00;
            cpr1_reg <= 32'h0;
            acc_rd_reg <= 32'h0;
        end else begin
            if (i_wr_stb && i_addr == FCI_ADDR_CTRL) ctrl_reg <= i_wr_data[7:0];
            if (i_wr_stb && i_addr == 4'h4) cfg0_reg <= i_wr_data[4:0];
            if (i_wr_stb && i_addr == 4'h5) cfg1_reg <= i_wr_data[4:0];
            if (i_wr_stb && i_addr == 4'h9) cpr1_reg <= i_wr_data;
            acc_rd_reg <= o_analog_input_word[i_addr[1:0]];
        end
    end

    // Plain counting only when no reset source is active
    assign tot0 = cfg0_reg == 5'h01 && ctrl_reg == 8'h00;
    assign tot1 = cfg1_reg[1:0] == FCI_MODE_TOTAL && ctrl_reg == 8'h00;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    a_rd_idle_zero: assert property (!$past(i_rd_stb) |-> o_rd_data == 32'h0)
        else $error("read data not zero outside a read");
    a_acc_read: assert property (i_rd_stb && i_addr[3:2] == FCI_PAGE_ACC |=> o_rd_data == acc_rd_reg)
        else $error("accumulator read differs from its word");
    a_unmapped_zero: assert property (i_rd_stb && i_addr inside {4'h1, 4'h2, 4'h3} |=> o_rd_data == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl_readback: assert property (i_rd_stb && i_addr == FCI_ADDR_CTRL |=> o_rd_data[7:0] == ctrl_reg)
        else $error("control read differs from written value");
    a_reset_hold: assert property (cfg0_reg[0] && ctrl_reg[0] && $past(ctrl_reg[0]) |->
        o_analog_input_word[0] == 32'h0)
        else $error("accumulator not held at zero");
    a_claim_zero: assert property (ctrl_reg[4] && $past(ctrl_reg[4]) |-> o_analog_input_word[2] == 32'h0)
        else $error("claimed input reports a value");
    a_total_step: assert property (tot0 && $past(tot0) && $changed(o_analog_input_word[0]) |->
        o_analog_input_word[0] == $past(o_analog_input_word[0]) + 32'h1 || o_analog_input_word[0] == 32'h0)
        else $error("totalizer moved by other than one");
    a_cpr_wrap: assert property (tot1 && cpr1_reg != 32'h0 && $changed(o_analog_input_word[1]) &&
        $past(o_analog_input_word[1]) == cpr1_reg - 32'h1 |-> o_analog_input_word[1] == 32'h0)
        else $error("counts per rev wrap missed");
    a_edge_delay: assert property ($rose(i_fast_count_input[0]) && tot0 |-> ##[1:4] $changed(o_analog_input_word[0]))
        else $error("rising edge not counted in time");
    a_count_once: assert property (tot0 && $changed(o_analog_input_word[0]) |=> $stable(o_analog_input_word[0]) [*3])
        else $error("one edge counted twice");
    a_falling_only: assert property (tot1 && cfg1_reg[2] && $rose(i_fast_count_input[1]) |->
        ##1 $stable(o_analog_input_word[1]) [*4])
        else $error("rising edge counted on falling setting");
endmodule

bind fci_counter_top fci_counter_asserts fci_counter_asserts_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_fast_count_input(i_fast_count_input), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb),
    .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .o_analog_input_word(o_analog_input_word));

`default_nettype wire

// *** fci_pulse_src.sv ***
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// Field pulse source: one square wave per running pin
// ----------------------------------------------------------------------------
module fci_pulse_src
    import fci_pkg::*;
#(
    parameter int HALF = 400
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [3:0] i_run,
    output logic [3:0] o_pins
);
    int cnt [4];

    // Levels last HALF clocks; a stopped pin ends its high phase and rests low
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pins <= 4'h0;
            cnt <= '{0, 0, 0, 0};
        end else begin
            for (int k = 0; k < 4; k++) begin
                if ((i_run[k] || o_pins[k]) && cnt[k] == HALF - 1) begin
                    o_pins[k] <= !o_pins[k];
                    cnt[k] <= 0;
                end else if (i_run[k] || o_pins[k]) begin
                    cnt[k] <= cnt[k] + 1;
                end else begin
                    cnt[k] <= 0;
                end
            end
        end
    end
endmodule

`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/100ps
`default_nettype none

module testbench
    import fci_pkg::*;
;
    localparam int TICK = 4;
    localparam int HALF = FCI_MIN_EDGE_GAP_US * TICK;
    localparam int WIN_US [4] = '{2000, 1000, 400, 200};
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic [3:0] pins;
    logic [3:0] run = 4'h0;
    logic [3:0] pin_q = 4'h0;
    logic [FCI_ADDR_W-1:0] i_addr = 4'h0;
    logic [31:0] i_wr_data = 32'h0;
    logic i_wr_stb = 1'b0;
    logic i_rd_stb = 1'b0;
    logic [31:0] o_rd_data;
    logic [3:0][31:0] o_analog_input_word;
    logic [31:0] seed = 32'h0000_003B;
    logic [31:0] rdv;
    int err_count = 0;
    int num_checks = 0;
    int rise_n [4] = '{0, 0, 0, 0};
    int fall_n [4] = '{0, 0, 0, 0};
    int n;
    int r0;
    always #2.5 i_clock = ~i_clock;
    fci_pulse_src #(.HALF(HALF)) fci_pulse_src_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_run(run), .o_pins(pins));

    // Short windows keep the run brief; all still divide one second
    fci_counter_top #(.WIN0_US(2000), .WIN1_US(1000), .WIN2_US(400), .WIN3_US(200), .TICK_CYCLES(TICK))
    fci_counter_top_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_fast_count_input(pins), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
        .o_analog_input_word(o_analog_input_word));

    // Pin edges give the expected totals
    always @(posedge i_clock) begin
        for (int k = 0; k < 4; k++) begin
            if (pins[k] && !pin_q[k]) rise_n[k]++;
            if (!pins[k] && pin_q[k]) fall_n[k]++;
        end
        pin_q <= pins;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Rising edges in one window times windows per second
    function automatic logic [31:0] exp_hz(input int win_us);
        return 32'((win_us * TICK / (2 * HALF)) * (FCI_US_PER_S / win_us));
    endfunction

    function automatic logic [31:0] wrap(input int cnt, input int cpr);
        return (cpr == 0) ? 32'(cnt) : 32'(cnt % cpr);
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_clk(input int c);
        repeat (c) @(posedge i_clock);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr_stb <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clock);
        i_wr_stb <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge i_clock);
        i_rd_stb <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd_stb <= 1'b0;
        #1;
        rdv = o_rd_data;
    endtask

    task automatic report_and_stop();
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #400000;
        err_count++;
        report_and_stop();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        wait_clk(10);
        i_rst_n <= 1'b1;
        wait_clk(2);
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0]);
            chk("reset word", rdv, 32'h0);
            chk("ai word", o_analog_input_word[a[1:0]], 32'h0);
        end
        // One tone must read the same hertz in every window
        run[2] <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(4'h6, 32'(s) << FCI_CFG_WIN_LSB);
            wait_clk(2 * WIN_US[s] * TICK + 20);
            rd(4'hE);
            chk("freq acc", rdv, exp_hz(WIN_US[s]));
            chk("freq word", o_analog_input_word[2], exp_hz(WIN_US[s]));
        end
        run[2] <= 1'b0;
        // Checked while high, so rising and falling totals differ by one
        wr(4'h4, 32'h1);
        wr(4'h5, 32'h5);
        seed = xs(seed);
        n = 2 + int'(seed % 7);
        r0 = rise_n[0];
        run[1:0] <= 2'h3;
        repeat (n) @(posedge pins[0]);
        wait_clk(50);
        rd(4'hC);
        chk("rise count", rdv, wrap(rise_n[0] - r0, 0));
        rd(4'hD);
        chk("fall count", rdv, 32'(fall_n[1]));
        wr(4'h4, 32'h3);
        rd(4'hD);
        chk("quad claim", rdv, 32'h0);
        wr(4'h4, 32'h1);
        run[1] <= 1'b0;
        wait_clk(2 * HALF);
        wr(4'h9, 32'h3);
        wr(4'h5, 32'h5);
        r0 = fall_n[1];
        seed = xs(seed);
        n = 3 + int'(seed % 7);
        run[1] <= 1'b1;
        repeat (n) @(negedge pins[1]);
        wait_clk(50);
        rd(4'hD);
        chk("wrap count", rdv, wrap(fall_n[1] - r0, 3));
        run[1] <= 1'b0;
        // Reset bit holds the total at zero under pulses
        wr(4'h0, 32'h1);
        wait_clk(4 * HALF);
        rd(4'hC);
        chk("held acc", rdv, 32'h0);
        rd(4'h0);
        chk("ctrl", rdv, 32'h1);
        @(negedge pins[0]);
        wr(4'h0, 32'h0);
        r0 = rise_n[0];
        seed = xs(seed);
        n = 2 + int'(seed % 5);
        repeat (n) @(posedge pins[0]);
        wait_clk(50);
        rd(4'hC);
        chk("count after release", rdv, 32'(rise_n[0] - r0));
        run[0] <= 1'b0;
        wait_clk(2 * HALF);
        // Third input as a rising-edge reset of the first totalizer
        wr(4'h0, 32'h10);
        rd(4'hE);
        chk("claimed acc", rdv, 32'h0);
        run[2] <= 1'b1;
        @(posedge pins[2]);
        run[2] <= 1'b0;
        wait_clk(50);
        rd(4'hC);
        chk("hw reset acc", rdv, 32'h0);
        report_and_stop();
    end
endmodule

`default_nettype wire
